// *** rtl/fsp_map.vh ***
// Constants for the fuse, identification and parallel programming block
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// ***************************************************
// Fuse byte reset values
// ***************************************************
`define FSP_EXT_FUSE_RESET   8'hFF
`define FSP_HIGH_FUSE_RESET  8'h99
`define FSP_LOW_FUSE_RESET   8'h62

// ***************************************************
// Fuse field positions
// ***************************************************
`define FSP_EXT_BOD_HI       3
`define FSP_EXT_BOD_LO       1
`define FSP_EXT_FTEST        0
`define FSP_HI_OCD           7
`define FSP_HI_SCAN          6
`define FSP_HI_SERDL         5
`define FSP_HI_WDON          4
`define FSP_HI_EEPRES        3
`define FSP_HI_BOOT_HI       2
`define FSP_HI_BOOT_LO       1
`define FSP_HI_RSTVEC        0
`define FSP_LO_DIV8          7
`define FSP_LO_SYSCLK_PIN_OUTPUT         6
`define FSP_LO_SUT_HI        5
`define FSP_LO_SUT_LO        4
`define FSP_LO_CKSRC_HI      3
`define FSP_LO_CKSRC_LO      0
`define FSP_LOCK_FIRST       0

// ***************************************************
// Action-select codes
// ***************************************************
`define FSP_ACT_ADDR         2'h0
`define FSP_ACT_DATA         2'h1
`define FSP_ACT_CMD          2'h2
`define FSP_ACT_IDLE         2'h3

// ***************************************************
// Command bytes
// ***************************************************
`define FSP_CMD_ERASE        8'h80
`define FSP_CMD_WR_FUSE      8'h40
`define FSP_CMD_WR_LOCK      8'h20
`define FSP_CMD_WR_FLASH     8'h10
`define FSP_CMD_WR_EEP       8'h11
`define FSP_CMD_RD_ID        8'h08
`define FSP_CMD_RD_FUSE      8'h04
`define FSP_CMD_RD_FLASH     8'h02
`define FSP_CMD_RD_EEP       8'h03

// ***************************************************
// Identification bytes (values arbitrary)
// ***************************************************
`define FSP_ID_BYTE0         8'hA5
`define FSP_ID_BYTE1         8'h5A
`define FSP_ID_BYTE2         8'h3C
`define FSP_CAL_RESET        8'h80

// ***************************************************
// Timing
// ***************************************************
`define FSP_CLK_NS           40
`define FSP_BUSY_NS          1000
`define FSP_BUSY_CYC         ((`FSP_BUSY_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// *** rtl/fsp_sync.v ***
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
`default_nettype none
module fsp_sync (
	// Clock and reset
	input  wire clk_i,
	input  wire resetn_i,
	// Async level in, clean level and edges out
	input  wire d_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_q;
	reg sync_q;
	reg prev_q;
	// First stage feeds only the second stage
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q;
	assign fall_o  = ~sync_q & prev_q;
endmodule // fsp_sync
`default_nettype wire

// *** rtl/fsp_busy_timer.v ***
// Busy timer that holds ready low for a fixed operation time
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.vh"
module fsp_busy_timer (
	// Clock and reset
	input  wire clk_i,
	input  wire resetn_i,
	// Start and state
	input  wire start_i,
	output wire busy_o,
	output wire done_o
);
	// Count is cut to the counter width on purpose
	localparam integer BUSY_FULL = `FSP_BUSY_CYC;
	localparam [7:0]   BUSY_CYC  = BUSY_FULL[7:0];
	reg [7:0] cnt_q;
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 8'h00;
		end else if (start_i) begin
			cnt_q <= BUSY_CYC;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	assign busy_o = (cnt_q != 8'h00);
	assign done_o = (cnt_q == 8'h01);
endmodule // fsp_busy_timer
`default_nettype wire

// *** rtl/fsp_prog_port.v ***
// Fuse store, identification bytes and parallel programming port
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.vh"
module fsp_prog_port (
	// Clock and reset
	input  wire       clk_i,
	input  wire       resetn_i,
	// Mode
	input  wire       prog_mode_i,
	input  wire       serial_mode_i,
	// Programmer strobes
	input  wire       crystal_input_pin_i,
	input  wire       write_n_i,
	input  wire       output_enable_n_i,
	input  wire       page_load_strobe_i,
	input  wire       action_select_0_i,
	input  wire       action_select_1_i,
	input  wire       byte_select_a_i,
	input  wire       byte_select_b_i,
	// Data bus
	input  wire [7:0] data_i,
	output reg  [7:0] data_o,
	output wire       data_oe_o,
	output wire       ready_busy_out_o,
	// Fuse effects
	output reg  [7:0] low_fuse_o,
	output reg  [7:0] high_fuse_o,
	output reg  [7:0] ext_fuse_o,
	output wire       eeprom_preserve_o,
	output wire       sysclk_pin_en_o,
	output reg  [7:0] osc_trim_register_o,
	// Memory core side
	output reg  [7:0] lock_bits_o,
	output reg  [15:0] address_o,
	output reg  [15:0] page_word_o,
	output reg        page_load_o,
	output reg        erase_o,
	output reg        mem_write_o
);
	// ***************************************************
	// Strobe synchronisers
	// ***************************************************
	wire xtal_rise;
	wire wr_fall;
	wire oe_act;
	wire pgl_rise;
	wire write_act = ~write_n_i;
	wire oe_in_act = ~output_enable_n_i;
	fsp_sync u_xtal (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(crystal_input_pin_i),
		.level_o(), .rise_o(xtal_rise), .fall_o());
	// Active-low strobes enter inverted so the reset value matches their idle level
	fsp_sync u_wr (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(write_act),
		.level_o(), .rise_o(wr_fall), .fall_o());
	fsp_sync u_oe (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(oe_in_act),
		.level_o(oe_act), .rise_o(), .fall_o());
	fsp_sync u_pgl (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(page_load_strobe_i),
		.level_o(), .rise_o(pgl_rise), .fall_o());

	// ***************************************************
	// Mode edge detection
	// ***************************************************
	reg prog_q;
	reg start_q;
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prog_q  <= 1'b0;
			start_q <= 1'b1;
		end else begin
			prog_q  <= prog_mode_i;
			start_q <= 1'b0;
		end
	end
	wire enter_prog = prog_mode_i & ~prog_q;
	wire exit_prog  = ~prog_mode_i & prog_q;

	// ***************************************************
	// Command, address and data holding registers
	// ***************************************************
	reg [7:0] cmd_q;
	reg [7:0] data_lo_q;
	reg [7:0] data_hi_q;
	wire [1:0] action = {action_select_1_i, action_select_0_i};
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_q     <= 8'h00;
			address_o <= 16'h0000;
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
		end else if (xtal_rise && prog_mode_i) begin
			case (action)
			`FSP_ACT_ADDR: begin
				if (byte_select_a_i)
					address_o[15:8] <= data_i;
				else
					address_o[7:0] <= data_i;
			end
			`FSP_ACT_DATA: begin
				if (byte_select_a_i)
					data_hi_q <= data_i;
				else
					data_lo_q <= data_i;
			end
			`FSP_ACT_CMD: cmd_q <= data_i;
			default: cmd_q <= cmd_q;
			endcase
		end
	end

	// ***************************************************
	// Page load
	// ***************************************************
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			page_word_o <= 16'h0000;
			page_load_o <= 1'b0;
		end else begin
			page_load_o <= pgl_rise & prog_mode_i;
			if (pgl_rise && prog_mode_i)
				page_word_o <= {data_hi_q, data_lo_q};
		end
	end

	// ***************************************************
	// Write operations and busy
	// ***************************************************
	wire busy;
	wire done;
	wire wr_go = wr_fall & prog_mode_i & ~busy;
	// A strobe during busy is dropped; the programmer must wait for ready
	fsp_busy_timer u_busy (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(wr_go),
		.busy_o(busy), .done_o(done));
	assign ready_busy_out_o = ~busy;

	reg [7:0] nv_low_q;
	reg [7:0] nv_high_q;
	reg [7:0] nv_ext_q;
	wire fuse_locked = ~lock_bits_o[`FSP_LOCK_FIRST];
	reg [7:0] high_wr;
	always @* begin
		high_wr = data_i;
		// Serial download fuse keeps its value when written from serial mode
		if (serial_mode_i)
			high_wr[`FSP_HI_SERDL] = nv_high_q[`FSP_HI_SERDL];
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nv_low_q    <= `FSP_LOW_FUSE_RESET;
			nv_high_q   <= `FSP_HIGH_FUSE_RESET;
			nv_ext_q    <= `FSP_EXT_FUSE_RESET;
			lock_bits_o <= 8'hFF;
			erase_o     <= 1'b0;
			mem_write_o <= 1'b0;
		end else begin
			erase_o     <= 1'b0;
			mem_write_o <= 1'b0;
			if (wr_go) begin
				case (cmd_q)
				`FSP_CMD_ERASE: begin
					// Only locks are cleared, fuses untouched
					lock_bits_o <= 8'hFF;
					erase_o     <= 1'b1;
				end
				`FSP_CMD_WR_FUSE: begin
					if (!fuse_locked) begin
						if (byte_select_b_i)
							nv_ext_q <= data_i;
						else if (byte_select_a_i)
							nv_high_q <= high_wr;
						else
							nv_low_q <= data_i;
					end
				end
				`FSP_CMD_WR_LOCK: lock_bits_o <= lock_bits_o & data_i;
				`FSP_CMD_WR_FLASH: mem_write_o <= 1'b1;
				`FSP_CMD_WR_EEP: mem_write_o <= 1'b1;
				default: mem_write_o <= 1'b0;
				endcase
			end
		end
	end

	// ***************************************************
	// Fuse latching
	// ***************************************************
	// Latched copy drives the fuse outputs and clock pin enable; eeprom_preserve_o reads the stored high fuse, so it moves mid-session
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_fuse_o  <= `FSP_LOW_FUSE_RESET;
			high_fuse_o <= `FSP_HIGH_FUSE_RESET;
			ext_fuse_o  <= `FSP_EXT_FUSE_RESET;
		end else if (enter_prog || exit_prog || (start_q && !prog_mode_i)) begin
			low_fuse_o  <= nv_low_q;
			high_fuse_o <= nv_high_q;
			ext_fuse_o  <= nv_ext_q;
		end
	end
	assign eeprom_preserve_o = ~nv_high_q[`FSP_HI_EEPRES];
	assign sysclk_pin_en_o   = ~low_fuse_o[`FSP_LO_SYSCLK_PIN_OUTPUT];

	// ***************************************************
	// Calibration copy
	// ***************************************************
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			osc_trim_register_o <= `FSP_CAL_RESET;
		else if (start_q)
			osc_trim_register_o <= `FSP_CAL_RESET;
	end

	// ***************************************************
	// Read path
	// ***************************************************
	function [7:0] id_byte;
		input [1:0] a;
		begin
			case (a)
			2'h0: id_byte = `FSP_ID_BYTE0;
			2'h1: id_byte = `FSP_ID_BYTE1;
			2'h2: id_byte = `FSP_ID_BYTE2;
			default: id_byte = 8'hFF;
			endcase
		end
	endfunction

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_o <= 8'h00;
		end else begin
			case (cmd_q)
			`FSP_CMD_RD_ID: begin
				// Identification readable regardless of lock state
				if (byte_select_a_i)
					data_o <= osc_trim_register_o;
				else
					data_o <= id_byte(address_o[1:0]);
			end
			`FSP_CMD_RD_FUSE: begin
				if (byte_select_b_i && byte_select_a_i)
					data_o <= nv_high_q;
				else if (byte_select_b_i)
					data_o <= nv_ext_q;
				else if (byte_select_a_i)
					data_o <= lock_bits_o;
				else
					data_o <= nv_low_q;
			end
			default: data_o <= 8'hFF;
			endcase
		end
	end
	assign data_oe_o = prog_mode_i & oe_act;

endmodule // fsp_prog_port
`default_nettype wire

// *** sim/fsp_prog_port_properties.sv ***
// Checker for the fuse and programming port block
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module fsp_prog_port_properties (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       resetn_i,
	// Watched ports
	input wire logic       prog_mode_i,
	input wire logic       write_n_i,
	input wire logic       output_enable_n_i,
	input wire logic       data_oe_o,
	input wire logic       ready_busy_out_o,
	input wire logic [7:0] low_fuse_o,
	input wire logic [7:0] high_fuse_o,
	input wire logic [7:0] ext_fuse_o,
	input wire logic [7:0] lock_bits_o,
	input wire logic       eeprom_preserve_o,
	input wire logic       sysclk_pin_en_o,
	input wire logic       erase_o,
	input wire logic       mem_write_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	oe_idle_a: assert property (output_enable_n_i [*3] |-> !data_oe_o)
		else $error("Bus driven with read strobe idle");
	oe_mode_a: assert property (!prog_mode_i |-> !data_oe_o)
		else $error("Bus driven outside programming mode");
	busy_start_a: assert property ($fell(write_n_i) && prog_mode_i && ready_busy_out_o && lock_bits_o[0]
		|-> ##[1:4] !ready_busy_out_o) else $error("Ready stayed high after write strobe");
	busy_len_a: assert property ($fell(ready_busy_out_o) |-> ##23 !ready_busy_out_o ##[1:4] ready_busy_out_o)
		else $error("Busy time wrong");
	fuse_hold_a: assert property (prog_mode_i && $past(prog_mode_i)
		|-> $stable(low_fuse_o) && $stable(high_fuse_o) && $stable(ext_fuse_o)) else $error("Fuses moved in mode");
	clk_pin_a: assert property ($stable(low_fuse_o) |-> sysclk_pin_en_o == !low_fuse_o[6])
		else $error("Clock pin enable disagrees with fuse");
	keep_now_a: assert property (!prog_mode_i && !$past(prog_mode_i, 4) && $stable(high_fuse_o)
		|-> eeprom_preserve_o == !high_fuse_o[3]) else $error("Preserve flag disagrees with fuse");
	quiet_bus_a: assert property (!prog_mode_i && !$past(prog_mode_i, 4) |-> !erase_o && !mem_write_o)
		else $error("Core action outside programming mode");
	erase_once_a: assert property (erase_o |=> !erase_o)
		else $error("Erase pulse too long");
	cover property ($fell(ready_busy_out_o));
	cover property (data_oe_o);
	cover property (erase_o);
endmodule // fsp_prog_port_properties
bind fsp_prog_port fsp_prog_port_properties u_props (.clk_i, .resetn_i, .prog_mode_i, .write_n_i,
	.output_enable_n_i, .data_oe_o, .ready_busy_out_o, .low_fuse_o, .high_fuse_o, .ext_fuse_o,
	.lock_bits_o, .eeprom_preserve_o, .sysclk_pin_en_o, .erase_o, .mem_write_o);
`default_nettype wire

// *** sim/fsp_prog_model.sv ***
// Behavioural parallel programmer driving the port strobes
`timescale 1ns/100ps
`default_nettype none
// ****
// Programmer model
// ****
module fsp_prog_model (
	// Clock and device status
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	input  wire logic [7:0] bus_i,
	// Strobes and selects
	output var logic        xtal_o,
	output var logic        write_n_o,
	output var logic        oe_n_o,
	output var logic        page_load_o,
	output var logic [1:0]  action_o,
	output var logic        sel_a_o,
	output var logic        sel_b_o,
	// Data drive
	output var logic [7:0]  data_o,
	output var logic        drive_o
);
	// Eight clocks clears the pulse minimum with room for the synchroniser
	localparam int HOLD = 8;
	initial begin
		{xtal_o, page_load_o, sel_a_o, sel_b_o} = 4'h0;
		{write_n_o, oe_n_o, drive_o} = 3'h7;
		action_o = 2'h3;
		data_o = 8'h00;
	end
	task automatic load(input logic [1:0] act, input logic a, input logic b, input logic [7:0] v);
		@(negedge clk_i);
		action_o = act;
		sel_a_o = a;
		sel_b_o = b;
		data_o = v;
		drive_o = 1'b1;
		repeat (2) @(negedge clk_i);
		xtal_o = 1'b1;
		repeat (HOLD) @(negedge clk_i);
		xtal_o = 1'b0;
		repeat (HOLD) @(negedge clk_i);
	endtask
	// No new command until ready is back
	task automatic write(output int busy);
		busy = 0;
		write_n_o = 1'b0;
		repeat (HOLD) begin
			@(negedge clk_i);
			busy += (ready_i === 1'b0);
		end
		write_n_o = 1'b1;
		for (int i = 0; i < 80 && ready_i !== 1'b1; i++) begin
			@(negedge clk_i);
		end
	endtask
	task automatic read(input logic a, input logic b, output logic [7:0] v);
		@(negedge clk_i);
		sel_a_o = a;
		sel_b_o = b;
		drive_o = 1'b0;
		oe_n_o = 1'b0;
		repeat (HOLD) @(negedge clk_i);
		v = bus_i;
		@(negedge clk_i);
		oe_n_o = 1'b1;
		repeat (3) @(negedge clk_i);
		drive_o = 1'b1;
	endtask
	task automatic page();
		@(negedge clk_i);
		page_load_o = 1'b1;
		repeat (HOLD) @(negedge clk_i);
		page_load_o = 1'b0;
		repeat (HOLD) @(negedge clk_i);
	endtask
endmodule // fsp_prog_model
`default_nettype wire

// *** sim/fsp_prog_port_tb_top.sv ***
// Self-checking bench for the fuse and programming port block
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.vh"
// ****
// Bench top
// ****
module fsp_prog_port_tb_top;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic prog_mode_i = 1'b0;
	logic serial_mode_i = 1'b0;
	int   miscompares = 0;
	int   tests_run = 0;
	int   cycles = 0;
	wire logic       crystal_input_pin_i, write_n_i, output_enable_n_i, page_load_strobe_i, drive;
	wire logic       action_select_0_i, action_select_1_i, byte_select_a_i, byte_select_b_i;
	wire logic       data_oe_o, ready_busy_out_o, eeprom_preserve_o, sysclk_pin_en_o;
	wire logic [1:0] act;
	wire logic [15:0] page_word_o;
	wire logic [7:0] pdata, data_i, data_o, low_fuse_o, high_fuse_o, ext_fuse_o, osc_trim_register_o, lock_bits_o;
	// A released bus shows the inverse of its last value, not a convenient constant
	assign data_i = data_oe_o ? data_o : (drive ? pdata : ~pdata);
	assign {action_select_1_i, action_select_0_i} = act;
	fsp_prog_port uut (.clk_i, .resetn_i, .prog_mode_i, .serial_mode_i, .crystal_input_pin_i, .write_n_i,
		.output_enable_n_i, .page_load_strobe_i, .action_select_0_i, .action_select_1_i, .byte_select_a_i,
		.byte_select_b_i, .data_i, .data_o, .data_oe_o, .ready_busy_out_o, .low_fuse_o, .high_fuse_o, .ext_fuse_o,
		.eeprom_preserve_o, .sysclk_pin_en_o, .osc_trim_register_o, .lock_bits_o, .address_o(), .page_word_o,
		.page_load_o(), .erase_o(), .mem_write_o());
	fsp_prog_model prg (.clk_i, .ready_i(ready_busy_out_o), .bus_i(data_i), .xtal_o(crystal_input_pin_i),
		.write_n_o(write_n_i), .oe_n_o(output_enable_n_i), .page_load_o(page_load_strobe_i), .action_o(act),
		.sel_a_o(byte_select_a_i), .sel_b_o(byte_select_b_i), .data_o(pdata), .drive_o(drive));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		prg.load(`FSP_ACT_CMD, 1'b0, 1'b0, c);
	endtask
	// Order of e is high, locks, extended, low
	task automatic fuse_read_all(input logic [31:0] e);
		logic [7:0] v;
		cmd(`FSP_CMD_RD_FUSE);
		for (int i = 0; i < 4; i++) begin
			prg.read(i[1], i[0], v);
			chk("fuse read", e[8*i +: 8], v);
		end
	endtask
	task automatic fuse_write(input logic a, input logic b, input logic [7:0] v, output int busy);
		cmd(`FSP_CMD_WR_FUSE);
		prg.load(`FSP_ACT_DATA, a, b, v);
		prg.write(busy);
	endtask
	task automatic t_defaults();
		chk("low fuse", 8'h62, low_fuse_o);
		chk("high fuse", 8'h99, high_fuse_o);
		chk("ext fuse", 8'hFF, ext_fuse_o);
		chk("trim", `FSP_CAL_RESET, osc_trim_register_o);
		chk("clk pin", 8'h00, {7'h00, sysclk_pin_en_o});
		chk("bus enable", 8'h00, {7'h00, data_oe_o});
	endtask
	task automatic t_program();
		int busy;
		prog_mode_i = 1'b1;
		repeat (4) @(negedge clk_i);
		fuse_read_all(32'h99FFFF62);
		fuse_write(1'b0, 1'b0, 8'h22, busy);
		chk("busy seen", 8'h01, {7'h00, busy != 0});
		serial_mode_i = 1'b1;
		fuse_write(1'b1, 1'b0, 8'hB1, busy);
		serial_mode_i = 1'b0;
		chk("latched low", 8'h62, low_fuse_o);
		chk("latched high", 8'h99, high_fuse_o);
		chk("preserve", 8'h01, {7'h00, eeprom_preserve_o});
		fuse_read_all(32'h91FFFF22);
		cmd(`FSP_CMD_ERASE);
		prg.write(busy);
		chk("erase busy", 8'h01, {7'h00, busy != 0});
		fuse_read_all(32'h91FFFF22);
		cmd(`FSP_CMD_WR_FLASH);
		prg.load(`FSP_ACT_DATA, 1'b0, 1'b0, 8'h34);
		prg.load(`FSP_ACT_DATA, 1'b1, 1'b0, 8'h12);
		prg.page();
		chk("page low", 8'h34, page_word_o[7:0]);
		chk("page high", 8'h12, page_word_o[15:8]);
	endtask
	task automatic t_lock_and_ident();
		int busy;
		logic [7:0] v;
		logic [7:0] ids [3] = '{`FSP_ID_BYTE0, `FSP_ID_BYTE1, `FSP_ID_BYTE2};
		cmd(`FSP_CMD_WR_LOCK);
		prg.load(`FSP_ACT_DATA, 1'b0, 1'b0, 8'hFE);
		prg.write(busy);
		fuse_write(1'b0, 1'b1, 8'h00, busy);
		fuse_read_all(32'h91FEFF22);
		cmd(`FSP_CMD_RD_ID);
		for (int i = 0; i < 3; i++) begin
			prg.load(`FSP_ACT_ADDR, 1'b0, 1'b0, i[7:0]);
			prg.read(1'b0, 1'b0, v);
			chk("ident", ids[i], v);
		end
		prg.load(`FSP_ACT_ADDR, 1'b0, 1'b0, 8'h00);
		prg.read(1'b1, 1'b0, v);
		chk("calibration", `FSP_CAL_RESET, v);
	endtask
	task automatic t_exit();
		prog_mode_i = 1'b0;
		repeat (6) @(negedge clk_i);
		chk("exit low", 8'h22, low_fuse_o);
		chk("exit high", 8'h91, high_fuse_o);
		chk("exit ext", 8'hFF, ext_fuse_o);
		chk("clk pin on", 8'h01, {7'h00, sysclk_pin_en_o});
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		t_defaults();
		t_program();
		t_lock_and_ident();
		t_exit();
		report_and_stop();
	end
endmodule // fsp_prog_port_tb_top
`default_nettype wire
